// >>> verilog/sme_defs.svh
// timing counts and field positions for the serial word memory
// assumes a 50 MHz system clock
`ifndef SME_DEFS_SVH
`define SME_DEFS_SVH

`define SME_CLK_MHZ 50
`define SME_PROG_TIME_MS 10
// longest time in whole system cycles; 10 ms at 50 MHz needs no rounding
`define SME_PROG_CYCLES ((`SME_PROG_TIME_MS * 1000 * `SME_CLK_MHZ))
`define SME_WORDS 64
`define SME_ADDR_W 6
`define SME_DATA_W 16
`define SME_INSTR_BITS 9
`define SME_ERASED_WORD 16'hFFFF

`endif

// >>> verilog/sme_pkg.sv
// types shared by the serial word memory
// assumes nothing beyond the header of constants
`default_nettype none
package sme_pkg;
    typedef enum {
        SME_IDLE,
        SME_CMD,
        SME_DATA,
        SME_READ,
        SME_ARMED,
        SME_PROG,
        SME_DONE
    } sme_state_t;
    typedef enum logic [2:0] {
        SME_OP_NONE,
        SME_OP_READ,
        SME_OP_WRITE,
        SME_OP_ERASE,
        SME_OP_EN,
        SME_OP_DIS,
        SME_OP_ERALL,
        SME_OP_WRALL
    } sme_op_t;
endpackage
`default_nettype wire

// >>> verilog/sme_sync.sv
// two flip-flop synchroniser for pins
// assumes the input is asynchronous to clk_i
`default_nettype none
module sme_sync (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/sme_mem.sv
// 64 x 16 storage array with registered read and bulk write
// assumes one clock; bulk writes take a single cycle
`default_nettype none
module sme_mem #(
    parameter int WORDS = 64,
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic wr_i,
    input wire logic all_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_reg [WORDS];
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_word
            always_ff @(posedge clk_i) begin
                if (wr_i && (all_i || addr_i == AW'(gi))) begin
                    mem_reg[gi] <= wdata_i;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_reg[addr_i];
    end
endmodule
`default_nettype wire

// >>> verilog/sme_top.sv
// serial word memory: 64 x 16 array behind a three-wire select/clock/data link
// assumes the link pins are asynchronous and far slower than the 50 MHz clock
// Operation
// [RL1] instruction is nine bits: start one, two-bit opcode, six-bit address, msb first
// [RL2] first one received in a sequence is taken as the start marker
// [RL3] array holds 64 words of 16 bits, six address bits pick one
// [RL4] opcode 10 reads, 01 writes, 11 erases the addressed word
// [RL5] opcode 00: upper address 11 enable, 00 disable, 10 erase all, 01 write all
// [RL6] data out driven only for read data or busy status, else released
// [RL7] read loads the word, sends a dummy zero then sixteen data bits
// [RL8] read data changes on each rising serial clock edge
// [RL9] powers up programming-disabled; enable holds until disable instruction
// [RL10] host must enable programming before any write or erase acts
// [RL11] read works whether programming is enabled or not
// [RL12] erase starts on select falling edge and sets the word to all ones
// [RL13] select high during programming shows low while busy, high when ready
// [RL14] write takes sixteen data bits, select falling edge starts the cycle
// [RL15] host erases a word before writing it since writes only clear bits
// [RL16] erase all behaves like erase but sets all 64 words to ones
// [RL17] write all behaves like write but stores the pattern in every word
// [RL18] serial clock only needed while shifting bits in; the code also needs its rising edges to shift read data out
// [RL19] self-timed programming finishes within 10 ms
// [RL20] host holds select low at least 1 us between instructions
// [RL21] host keeps serial clock period at 4 us or more
// [RL22] only write, erase, erase all and write all change the array
// [RL23] select low with no programming running means standby
// [RL24] data in sampled on rising serial clock with select high; leading zeros ignored
// [RL25] partial instruction dropped at select fall; programming ignored while disabled
`default_nettype none
`include "sme_defs.svh"
module sme_top #(
    parameter int PROG_CYCLES = `SME_PROG_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CHIP_SELECT_I,
    input wire logic SERIAL_CLOCK_IN_I,
    input wire logic SERIAL_IN_LINE_I,
    output logic DATA_OUT_O,
    output logic DATA_OUT_OE_O,
    output logic STANDBY_O
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic cs_s;
    logic sk_s;
    logic di_s;
    logic cs_d_reg;
    logic sk_d_reg;
    sme_sync u_cs (
        .clk_i(SYS_CLK_I),
        .reset_n_i(RESET_N_I),
        .d_i(CHIP_SELECT_I),
        .q_o(cs_s)
    );
    sme_sync u_sk (
        .clk_i(SYS_CLK_I),
        .reset_n_i(RESET_N_I),
        .d_i(SERIAL_CLOCK_IN_I),
        .q_o(sk_s)
    );
    sme_sync u_di (
        .clk_i(SYS_CLK_I),
        .reset_n_i(RESET_N_I),
        .d_i(SERIAL_IN_LINE_I),
        .q_o(di_s)
    );
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            cs_d_reg <= 1'b0;
            sk_d_reg <= 1'b0;
        end else begin
            cs_d_reg <= cs_s;
            sk_d_reg <= sk_s;
        end
    end
    logic sk_rise;
    logic cs_fall;
    logic cs_rise;
    // data-in is two stages late like the clock, so they stay aligned
    assign sk_rise = sk_s && !sk_d_reg && cs_s; // [RL24]
    assign cs_fall = cs_d_reg && !cs_s;
    assign cs_rise = cs_s && !cs_d_reg;

    // ------------------------------------------------------------
    // instruction shifter and decode
    // ------------------------------------------------------------
    sme_pkg::sme_state_t state_reg;
    logic [7:0] cmd_reg;
    logic [3:0] cnt_reg;
    logic [`SME_DATA_W-1:0] sh_reg;
    logic en_reg;
    sme_pkg::sme_op_t op_reg;
    logic [PROG_CYCLES > 1 ? $clog2(PROG_CYCLES+1) : 1:0] tmr_reg;
    logic busy_show_reg;
    logic dout_reg;
    logic mem_wr;
    logic mem_all;
    logic [`SME_DATA_W-1:0] mem_wdata;
    logic [`SME_DATA_W-1:0] mem_rdata;
    logic [`SME_ADDR_W-1:0] addr;
    logic prog_op;

    function automatic sme_pkg::sme_op_t decode(input logic [7:0] c);
        case (c[7:6]) // [RL4]
            2'b10: decode = sme_pkg::SME_OP_READ;
            2'b01: decode = sme_pkg::SME_OP_WRITE;
            2'b11: decode = sme_pkg::SME_OP_ERASE;
            default: begin
                case (c[5:4]) // [RL5]
                    2'b11: decode = sme_pkg::SME_OP_EN;
                    2'b00: decode = sme_pkg::SME_OP_DIS;
                    2'b10: decode = sme_pkg::SME_OP_ERALL;
                    default: decode = sme_pkg::SME_OP_WRALL;
                endcase
            end
        endcase
    endfunction

    assign addr = cmd_reg[`SME_ADDR_W-1:0]; // [RL3]
    assign prog_op = (op_reg == sme_pkg::SME_OP_WRITE) || (op_reg == sme_pkg::SME_OP_ERASE)
        || (op_reg == sme_pkg::SME_OP_ERALL) || (op_reg == sme_pkg::SME_OP_WRALL);

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            state_reg <= sme_pkg::SME_IDLE;
            cmd_reg <= 8'h00;
            cnt_reg <= 4'h0;
            sh_reg <= 16'h0000;
            op_reg <= sme_pkg::SME_OP_NONE;
            tmr_reg <= '0;
            dout_reg <= 1'b0;
        end else begin
            case (state_reg)
                sme_pkg::SME_IDLE: begin
                    // leading zeros are skipped until the start marker
                    if (sk_rise && di_s) begin // [RL2]
                        state_reg <= sme_pkg::SME_CMD;
                        cnt_reg <= 4'h0;
                    end
                end
                sme_pkg::SME_CMD: begin
                    if (cs_fall) begin
                        state_reg <= sme_pkg::SME_IDLE; // [RL25]
                    end else if (sk_rise) begin
                        cmd_reg <= {cmd_reg[6:0], di_s}; // [RL1]
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == 4'h7) begin
                            op_reg <= decode({cmd_reg[6:0], di_s});
                            cnt_reg <= 4'h0;
                            dout_reg <= 1'b0; // dummy zero stands until the first data rise [RL7]
                            case (decode({cmd_reg[6:0], di_s}))
                                sme_pkg::SME_OP_READ: state_reg <= sme_pkg::SME_READ;
                                sme_pkg::SME_OP_WRITE,
                                sme_pkg::SME_OP_WRALL: state_reg <= sme_pkg::SME_DATA; // [RL14]
                                sme_pkg::SME_OP_ERASE,
                                sme_pkg::SME_OP_ERALL: state_reg <= sme_pkg::SME_ARMED;
                                default: state_reg <= sme_pkg::SME_DONE;
                            endcase
                        end
                    end
                end
                sme_pkg::SME_DATA: begin
                    if (cs_fall) begin
                        state_reg <= sme_pkg::SME_IDLE;
                    end else if (sk_rise) begin
                        sh_reg <= {sh_reg[14:0], di_s};
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == 4'hF) begin
                            state_reg <= sme_pkg::SME_ARMED;
                        end
                    end
                end
                sme_pkg::SME_READ: begin
                    // mem_rdata is valid one cycle after decode; dummy zero goes first
                    if (cs_fall) begin
                        state_reg <= sme_pkg::SME_IDLE;
                    end else if (sk_rise) begin // [RL8]
                        if (cnt_reg == 4'h0) begin
                            sh_reg <= {mem_rdata[14:0], 1'b0}; // [RL7]
                            dout_reg <= mem_rdata[15];
                        end else begin
                            sh_reg <= {sh_reg[14:0], 1'b0};
                            dout_reg <= sh_reg[15];
                        end
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                sme_pkg::SME_ARMED: begin
                    // extra clocks after the last bit void the instruction
                    if (sk_rise) begin
                        state_reg <= sme_pkg::SME_DONE;
                    end else if (cs_fall) begin
                        if (en_reg) begin // [RL25]
                            state_reg <= sme_pkg::SME_PROG; // [RL12]
                            tmr_reg <= '0;
                        end else begin
                            state_reg <= sme_pkg::SME_IDLE;
                        end
                    end
                end
                sme_pkg::SME_PROG: begin
                    tmr_reg <= tmr_reg + ($bits(tmr_reg))'(1); // no serial clock needed [RL18]
                    if (tmr_reg == ($bits(tmr_reg))'(PROG_CYCLES - 1)) begin // [RL19]
                        state_reg <= sme_pkg::SME_IDLE;
                    end
                end
                sme_pkg::SME_DONE: begin
                    if (cs_fall) begin
                        state_reg <= sme_pkg::SME_IDLE;
                    end
                end
                default: state_reg <= sme_pkg::SME_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // programming enable latch
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            en_reg <= 1'b0; // [RL9]
        end else if (state_reg == sme_pkg::SME_DONE && cs_fall) begin
            if (op_reg == sme_pkg::SME_OP_EN) begin
                en_reg <= 1'b1;
            end else if (op_reg == sme_pkg::SME_OP_DIS) begin
                en_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // array write at the end of the timed cycle
    // ------------------------------------------------------------
    // the array is committed in the last cycle, so a reset mid-cycle leaves it intact
    assign mem_wr = (state_reg == sme_pkg::SME_PROG) && prog_op
        && (tmr_reg == ($bits(tmr_reg))'(PROG_CYCLES - 1)); // [RL22]
    assign mem_all = (op_reg == sme_pkg::SME_OP_ERALL) || (op_reg == sme_pkg::SME_OP_WRALL);
    assign mem_wdata = ((op_reg == sme_pkg::SME_OP_ERASE) || (op_reg == sme_pkg::SME_OP_ERALL))
        ? `SME_ERASED_WORD : (mem_rdata & sh_reg); // [RL16] [RL17]

    sme_mem #(
        .WORDS(`SME_WORDS),
        .AW(`SME_ADDR_W),
        .DW(`SME_DATA_W)
    ) u_mem (
        .clk_i(SYS_CLK_I),
        .wr_i(mem_wr),
        .all_i(mem_all),
        .addr_i(addr),
        .wdata_i(op_reg == sme_pkg::SME_OP_WRALL ? sh_reg : mem_wdata),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------
    // status and output enable
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            busy_show_reg <= 1'b0;
        end else if (cs_rise && (state_reg == sme_pkg::SME_PROG)) begin
            busy_show_reg <= 1'b1; // [RL13]
        end else if (!cs_s || (state_reg != sme_pkg::SME_PROG && sk_rise)) begin
            busy_show_reg <= 1'b0;
        end
    end

    always_comb begin
        DATA_OUT_OE_O = 1'b0;
        DATA_OUT_O = 1'b0;
        if (state_reg == sme_pkg::SME_READ && cs_s) begin // [RL6] [RL11]
            DATA_OUT_OE_O = 1'b1;
            DATA_OUT_O = dout_reg;
        end else if (busy_show_reg && cs_s) begin
            DATA_OUT_OE_O = 1'b1;
            DATA_OUT_O = (state_reg != sme_pkg::SME_PROG); // [RL13]
        end
    end

    assign STANDBY_O = !cs_s && (state_reg != sme_pkg::SME_PROG); // [RL23]

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence prog_start_s;
        state_reg == sme_pkg::SME_ARMED && cs_fall && en_reg;
    endsequence
    sequence prog_run_s;
        state_reg == sme_pkg::SME_PROG;
    endsequence
    sequence read_decode_s;
        state_reg == sme_pkg::SME_CMD && sk_rise && cnt_reg == 4'h7 && cmd_reg[6:5] == 2'b10;
    endsequence

    dout_release_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL6]
        !cs_s |-> !DATA_OUT_OE_O) else $error("data out driven with select low");
    powerup_disabled_a: assert property (@(posedge SYS_CLK_I) // [RL9]
        !RESET_N_I |=> !en_reg) else $error("enable not cleared at reset");
    prog_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL25]
        (state_reg == sme_pkg::SME_ARMED && cs_fall && !en_reg) |=> state_reg == sme_pkg::SME_IDLE)
        else $error("programming started while disabled");
    prog_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL12]
        prog_start_s |=> prog_run_s) else $error("select fall did not start cycle");
    array_guard_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL22]
        mem_wr |-> (prog_op && state_reg == sme_pkg::SME_PROG))
        else $error("array written outside programming");
    busy_low_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL13]
        ((busy_show_reg && cs_s) and prog_run_s) |-> (DATA_OUT_OE_O && !DATA_OUT_O))
        else $error("busy status not low");
    read_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL11]
        (state_reg == sme_pkg::SME_READ && cs_s) |-> DATA_OUT_OE_O)
        else $error("read data not driven");
    standby_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL23]
        (!cs_s && state_reg != sme_pkg::SME_PROG) |-> STANDBY_O) else $error("standby missing");
    read_dummy_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL7]
        read_decode_s |=> (state_reg == sme_pkg::SME_READ && !dout_reg))
        else $error("dummy zero missing before read data");
    read_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL8]
        (state_reg == sme_pkg::SME_READ && !sk_rise) |=> $stable(dout_reg))
        else $error("read bit changed without a serial rise");
    enable_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL9]
        (state_reg == sme_pkg::SME_DONE && cs_fall && op_reg == sme_pkg::SME_OP_EN) |=> en_reg)
        else $error("enable instruction not latched");
    enable_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL9]
        (state_reg == sme_pkg::SME_DONE && cs_fall && op_reg == sme_pkg::SME_OP_DIS) |=> !en_reg)
        else $error("disable instruction not latched");
    cmd_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL25]
        (state_reg == sme_pkg::SME_CMD && cs_fall) |=> state_reg == sme_pkg::SME_IDLE)
        else $error("partial instruction kept");
    prog_bound_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL19]
        prog_run_s |-> (tmr_reg < ($bits(tmr_reg))'(PROG_CYCLES)))
        else $error("programming cycle overran");
    erase_ones_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL12]
        (mem_wr && op_reg == sme_pkg::SME_OP_ERASE) |-> mem_wdata == `SME_ERASED_WORD)
        else $error("erase did not write ones");
    bulk_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESET_N_I) // [RL17]
        (mem_wr && op_reg == sme_pkg::SME_OP_WRALL) |-> mem_all)
        else $error("write all did not reach every word");
endmodule
`default_nettype wire

// >>> sim/sme_host.sv
// host model for the three-wire select/clock/data link of the serial word memory
// assumes a free-running system clock; link pins move 1 ns after its rising edge
`default_nettype none
module sme_host (
    input wire logic clk_i,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    output logic cs_o,
    output logic sk_o,
    output logic di_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_o = 1'b0;
        sk_o = 1'b0; // link clock stands still outside frames
        di_o = 1'b0;
    end

    // ----------------------------------------
    // link timing
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one link period is 8 system cycles, 160 ns; data set up before the rise
    task automatic put_bit(input logic b);
        di_o = b;
        tick(1);
        sk_o = 1'b1;
        tick(4);
        sk_o = 1'b0;
        tick(3);
    endtask

    // low bits of v, msb first; select comes up three cycles ahead of the first rise
    task automatic put_word(input logic [31:0] v, input int n);
        if (!cs_o) begin
            cs_o = 1'b1;
            tick(2);
        end
        for (int i = n - 1; i >= 0; i--) begin
            put_bit(v[i]);
        end
    endtask

    // select low for 1 us; idle data line is scrambled so nothing leans on it
    task automatic end_frame();
        cs_o = 1'b0;
        di_o = ~di_o;
        tick(50);
    endtask

    // ----------------------------------------
    // transfers
    // ----------------------------------------
    // got[16] is the dummy bit, sampled just before the first data rise
    task automatic read_word(input logic [5:0] a, input int lead, output logic [16:0] got,
                             output logic oe);
        put_word({23'h0, 1'b1, 2'b10, a}, 9 + lead);
        got[16] = dout_i;
        oe = dout_oe_i;
        for (int i = 15; i >= 0; i--) begin
            put_bit(1'b0);
            got[i] = dout_i;
            oe = oe & dout_oe_i;
        end
        end_frame();
    endtask

    // raise select during a cycle: first look must be busy, then ready within bound
    task automatic status(input int bound, output logic busy, output logic ready);
        cs_o = 1'b1;
        tick(5);
        busy = dout_oe_i & ~dout_i;
        ready = 1'b0;
        for (int i = 0; i < bound && !ready; i++) begin
            tick(1);
            ready = dout_oe_i & dout_i;
        end
        end_frame();
    endtask
endmodule
`default_nettype wire

// >>> sim/serial_eeprom_64x16_self_timed_tb.sv
// self-checking bench for the serial word memory top
// assumes the host model drives the link; programming shortened to PROG system cycles
`default_nettype none
module serial_eeprom_64x16_self_timed_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PROG = 400;
    logic SYS_CLK_I = 1'b0;
    logic RESET_N_I = 1'b0;
    wire logic cs;
    wire logic sk;
    wire logic di;
    logic DATA_OUT_O;
    logic DATA_OUT_OE_O;
    logic STANDBY_O;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

`define CHK(got, exp) check_eq(32'(got), 32'(exp))

    always #10 SYS_CLK_I = ~SYS_CLK_I;

    sme_top #(.PROG_CYCLES(PROG)) dut_u (
        .SYS_CLK_I(SYS_CLK_I),
        .RESET_N_I(RESET_N_I),
        .CHIP_SELECT_I(cs),
        .SERIAL_CLOCK_IN_I(sk),
        .SERIAL_IN_LINE_I(di),
        .DATA_OUT_O(DATA_OUT_O),
        .DATA_OUT_OE_O(DATA_OUT_OE_O),
        .STANDBY_O(STANDBY_O)
    );

    sme_host host_u (
        .clk_i(SYS_CLK_I),
        .dout_i(DATA_OUT_O),
        .dout_oe_i(DATA_OUT_OE_O),
        .cs_o(cs),
        .sk_o(sk),
        .di_o(di)
    );

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, about five times the expected run
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // shared operations
    // ----------------------------------------
    task automatic rd(input logic [5:0] a, input int lead, input logic [15:0] exp);
        logic [16:0] got;
        logic oe;
        host_u.read_word(a, lead, got, oe);
        `CHK(got, {1'b0, exp});
        `CHK(oe, 1'b1);
        `CHK(DATA_OUT_OE_O, 1'b0);
    endtask

    // d is left aligned: nd bits are sent from the top of it after the instruction
    task automatic prog(input logic [1:0] op, input logic [5:0] a, input logic [16:0] d,
                        input int nd, input logic run);
        logic busy;
        logic ready;
        host_u.put_word({6'h0, 1'b1, op, a, d} >> (17 - nd), 9 + nd);
        host_u.end_frame();
        if (run) begin
            `CHK(STANDBY_O, 1'b0);
            host_u.status(2 * PROG, busy, ready);
            `CHK(busy, 1'b1);
            `CHK(ready, 1'b1);
        end else begin
            `CHK(STANDBY_O, 1'b1);
            `CHK(DATA_OUT_OE_O, 1'b0);
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        `CHK(DATA_OUT_OE_O, 1'b0);
        `CHK(STANDBY_O, 1'b1);
        prog(2'b00, 6'h20, 17'h0, 0, 1'b0);
    endtask

    task automatic t_bulk();
        prog(2'b00, 6'h3A, 17'h0, 0, 1'b0);
        prog(2'b00, 6'h25, 17'h0, 0, 1'b1);
        rd(6'h00, 0, 16'hFFFF);
        rd(6'h3F, 0, 16'hFFFF);
        prog(2'b00, 6'h1C, {16'hA5C3, 1'b0}, 16, 1'b1);
        rd(6'h00, 0, 16'hA5C3);
        rd(6'h1F, 0, 16'hA5C3);
        rd(6'h3F, 0, 16'hA5C3);
    endtask

    task automatic t_single();
        prog(2'b11, 6'h07, 17'h0, 0, 1'b1);
        rd(6'h07, 0, 16'hFFFF);
        rd(6'h08, 0, 16'hA5C3);
        prog(2'b01, 6'h07, {16'h1234, 1'b0}, 16, 1'b1);
        rd(6'h07, 0, 16'h1234);
        prog(2'b01, 6'h08, {16'h0F0F, 1'b0}, 16, 1'b1);
        rd(6'h08, 0, 16'h0503);
    endtask

    task automatic t_disabled();
        prog(2'b00, 6'h0F, 17'h0, 0, 1'b0);
        prog(2'b11, 6'h07, 17'h0, 0, 1'b0);
        prog(2'b00, 6'h2A, 17'h0, 0, 1'b0);
        rd(6'h07, 0, 16'h1234);
        rd(6'h00, 0, 16'hA5C3);
    endtask

    // an extra rise after the last data bit must void the write
    task automatic t_voided();
        prog(2'b00, 6'h30, 17'h0, 0, 1'b0);
        prog(2'b01, 6'h09, 17'h00001, 17, 1'b0);
        rd(6'h09, 0, 16'hA5C3);
    endtask

    // leading zeros before the marker and a cut-off instruction
    task automatic t_framing();
        host_u.put_word(32'h0000_0014, 5);
        host_u.end_frame();
        `CHK(DATA_OUT_OE_O, 1'b0);
        rd(6'h07, 3, 16'h1234);
        rd(6'h3E, 1, 16'hA5C3);
    endtask

    // a reset in mid-run must drop a standing enable
    task automatic t_reset();
        RESET_N_I = 1'b0;
        repeat (10) @(posedge SYS_CLK_I);
        #1;
        RESET_N_I = 1'b1;
        repeat (3) @(posedge SYS_CLK_I);
        #1;
        `CHK(DATA_OUT_OE_O, 1'b0);
        `CHK(STANDBY_O, 1'b1);
        prog(2'b11, 6'h07, 17'h0, 0, 1'b0);
        rd(6'h07, 0, 16'h1234);
    endtask

    initial begin
        repeat (10) @(posedge SYS_CLK_I);
        #1;
        RESET_N_I = 1'b1;
        repeat (3) @(posedge SYS_CLK_I);
        #1;
        t_power_up();
        t_bulk();
        t_single();
        t_disabled();
        t_voided();
        t_framing();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
